// ==== rtl/iaeu_top.sv ====
`timescale 1ns/1ns
module iaeu_top
  import iaeu_pkg::*;
#(
  parameter logic [71:0] SERIAL_ID = 72'h5A_0123_4567_89AB_CDEF, // arbitrary value
  parameter int unsigned STORE_WAIT = STORE_WAIT_CYCLES
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // ISA bus pins
  input wire logic [15:0] isa_addr_in,
  input wire logic [7:0] isa_data_in,
  input wire logic isa_iow_in,
  input wire logic isa_ior_in,
  output logic [7:0] isa_data_out,
  output logic isa_data_oe_out,
  // EEROM control register port
  input wire logic eec_wr_in,
  input wire logic [7:0] eec_wdata_in,
  output logic [7:0] eec_rdata_out,
  // EEROM engine
  input wire logic store_done_in,
  output logic store_start_out,
  output logic recall_start_out,
  output logic [4:0] store_bank_out,
  // Enable and strap
  input wire logic autoconfig_enable_in,
  input wire logic strap_address_pin_six_in,
  // Activation
  output logic cfg_shift_out,
  output logic card_active_out
);
  import iaeu_pkg::*;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int SYNC_W = 16 + 8 + 3;
  logic [SYNC_W-1:0] pin_sync1_reg;
  logic [SYNC_W-1:0] pin_sync2_reg;
  logic [15:0] addr_s;
  logic [7:0] data_s;
  logic iow_s;
  logic ior_s;
  logic strap_s;
  logic iow_d_reg;
  logic ior_d_reg;

  assign {strap_s, ior_s, iow_s, data_s, addr_s} = pin_sync2_reg;

  always_ff @(posedge clk_in)
  begin
    pin_sync1_reg <= {strap_address_pin_six_in, isa_ior_in, isa_iow_in, isa_data_in, isa_addr_in};
    pin_sync2_reg <= pin_sync1_reg;
    iow_d_reg <= reset_in ? 1'b0 : iow_s;
    ior_d_reg <= reset_in ? 1'b0 : ior_s;
  end

  // ----------------------------------------
  // EEROM unlock and store
  // ----------------------------------------
  logic [7:0] eec_reg;
  iaeu_unlock_t unlock_reg;
  iaeu_unlock_t unlock_next;
  logic [STORE_CNT_W-1:0] wait_reg;
  logic store_busy_next;

  wire eec_is_first = (eec_wdata_in & EEC_SEQ_MASK) == EEC_FIRST;
  wire eec_is_second = (eec_wdata_in & EEC_SEQ_MASK) == EEC_SECOND;
  wire eec_is_third = eec_wdata_in[EEC_STORE_BIT] && !eec_wdata_in[EEC_RECALL_BIT]
                    && !eec_wdata_in[EEC_UNLOCK_BIT];
  wire store_go = eec_wr_in && (unlock_reg == unlock_armed) && eec_is_third;
  wire store_end = store_done_in || (wait_reg == '0);

  always_comb
  begin
    unlock_next = unlock_reg;
    if (eec_wr_in)
    begin
      unique case (unlock_reg)
        unlock_idle: unlock_next = eec_is_first ? unlock_first : unlock_idle;
        unlock_first: unlock_next = eec_is_second ? unlock_armed : unlock_idle;
        unlock_armed: unlock_next = unlock_idle;
        default: unlock_next = unlock_idle;
      endcase
    end
  end

  // store bit held until done or timeout, set wins
  assign store_busy_next = store_go || (eec_reg[EEC_STORE_BIT] && !store_end);

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      eec_reg <= EEC_RESET;
      unlock_reg <= unlock_idle;
      wait_reg <= '0;
    end
    else
    begin
      eec_reg[EEC_STORE_BIT] <= store_busy_next;
      if (eec_wr_in)
        eec_reg[EEC_RECALL_BIT:0] <= eec_wdata_in[EEC_RECALL_BIT:0];
      unlock_reg <= unlock_next;
      wait_reg <= store_go ? STORE_CNT_W'(STORE_WAIT) : (wait_reg != '0 ? wait_reg - 1'b1 : wait_reg);
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      store_start_out <= 1'b0;
      recall_start_out <= 1'b0;
      store_bank_out <= '0;
    end
    else
    begin
      store_start_out <= store_go;
      recall_start_out <= eec_wr_in && eec_wdata_in[EEC_RECALL_BIT] && !eec_wdata_in[EEC_STORE_BIT];
      if (store_go)
        store_bank_out <= iaeu_bank_of(eec_wdata_in);
    end
  end

  assign eec_rdata_out = eec_reg;

  // ----------------------------------------
  // Port decode
  // ----------------------------------------
  iaeu_pnp_state_t state_reg;
  iaeu_pnp_state_t state_next;
  logic [7:0] index_reg;
  logic [7:0] csn_reg;
  logic [7:0] rd_port_reg;
  logic activate_reg;
  logic [4:0] shift_cnt_reg;
  logic [ID_PTR_W-1:0] bit_ptr_reg;
  logic iso_phase_reg;
  logic saw_first_reg;
  logic iso_read_reg;
  logic key_found;
  logic [7:0] res_mem [RES_DEPTH];

  // enable bit and strap both needed
  wire pnp_on = autoconfig_enable_in && strap_s;
  wire iow_rise = iow_s && !iow_d_reg;
  wire ior_rise = ior_s && !ior_d_reg;
  wire ior_fall = !ior_s && ior_d_reg;
  wire awake = (state_reg != await_key_state);
  wire [15:0] rd_addr = {RD_PORT_PAD, rd_port_reg, RD_PORT_LOW};
  // data ports dead before the key
  wire wr_index = pnp_on && iow_rise && addr_s == ISA_INDEX_PORT;
  wire wr_data = pnp_on && awake && iow_rise && addr_s == ISA_WDATA_PORT;
  wire rd_hit = pnp_on && (state_reg == isolate_state || state_reg == config_state) && addr_s == rd_addr;
  wire wr_ctrl = wr_data && index_reg == IDX_CFG_CTRL;
  wire wr_wake = wr_data && index_reg == IDX_WAKE;
  wire wr_csn = wr_data && index_reg == IDX_CSN && (state_reg == isolate_state || state_reg == config_state);
  wire wr_setrd = wr_data && index_reg == IDX_SET_RD && state_reg == isolate_state;
  wire wr_act = wr_data && index_reg == IDX_ACTIVATE && state_reg == config_state;
  wire res_hit = index_reg[7:RES_OFS_W] == IDX_RES_BASE[7:RES_OFS_W];
  wire [RES_OFS_W-1:0] res_ofs = index_reg[RES_OFS_W-1:0];
  wire cmd_to_key = wr_ctrl && (data_s[CTRL_RESET_BIT] || data_s[CTRL_WAIT_KEY_BIT]);
  wire wake_match = (data_s == csn_reg);
  wire cur_bit = (bit_ptr_reg < ID_PTR_W'(ID_BITS)) && SERIAL_ID[bit_ptr_reg];
  wire iso_read = rd_hit && index_reg == IDX_ISOLATE && state_reg == isolate_state;
  wire iso_lost = ior_fall && iso_read_reg && iso_phase_reg && !cur_bit && saw_first_reg && data_s == ISO_SECOND;

  iaeu_key_match u_key
  (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .enable_in(pnp_on && !awake),
    .wr_in(wr_index),
    .data_in(data_s),
    .found_out(key_found)
  );

  // ----------------------------------------
  // State machine
  // ----------------------------------------
  // wait-for-key entry and gating
  always_comb
  begin
    state_next = state_reg;
    if (!pnp_on)
      state_next = await_key_state;
    else
    begin
      unique case (state_reg)
        await_key_state: state_next = key_found ? sleep_state : await_key_state;
        sleep_state, isolate_state, config_state:
        begin
          if (cmd_to_key)
            state_next = await_key_state;
          else if (wr_wake)
            state_next = !wake_match ? sleep_state : (csn_reg == '0 ? isolate_state : config_state);
          else if (state_reg == isolate_state && iso_lost)
            state_next = sleep_state;
          else if (state_reg == isolate_state && wr_csn)
            state_next = config_state;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      state_reg <= await_key_state;
      index_reg <= '0;
      csn_reg <= '0;
      rd_port_reg <= RD_PORT_RESET;
      activate_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (wr_index)
        index_reg <= data_s;
      if (wr_csn)
        csn_reg <= data_s;
      else if (wr_ctrl && data_s[CTRL_CSN_CLR_BIT])
        csn_reg <= '0;
      if (wr_setrd)
        rd_port_reg <= data_s;
      if (wr_act)
        activate_reg <= data_s[ACTIVATE_BIT];
      else if ((wr_ctrl && data_s[CTRL_RESET_BIT]) || !pnp_on)
        activate_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      for (int i = 0; i < RES_DEPTH; i++)
        res_mem[i] <= '0;
    end
    else if (wr_data && res_hit && state_reg == config_state)
      res_mem[res_ofs] <= data_s;
  end

  // ----------------------------------------
  // Isolation
  // ----------------------------------------
  // wake zero restarts pointer
  always_ff @(posedge clk_in)
  begin
    if (reset_in || (wr_wake && wake_match && csn_reg == '0))
    begin
      bit_ptr_reg <= '0;
      iso_phase_reg <= 1'b0;
      saw_first_reg <= 1'b0;
      iso_read_reg <= 1'b0;
    end
    else if (ior_rise)
      iso_read_reg <= iso_read;
    else if (ior_fall && iso_read_reg)
    begin
      iso_read_reg <= 1'b0;
      iso_phase_reg <= !iso_phase_reg;
      saw_first_reg <= !iso_phase_reg && data_s == ISO_FIRST;
      if (iso_phase_reg && bit_ptr_reg < ID_PTR_W'(ID_BITS))
        bit_ptr_reg <= bit_ptr_reg + 1'b1;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  // answer pattern for a one bit
  wire [7:0] iso_value = iso_phase_reg ? ISO_SECOND : ISO_FIRST;
  wire [7:0] rd_value = (index_reg == IDX_ISOLATE) ? iso_value
                      : (index_reg == IDX_CSN) ? csn_reg
                      : (index_reg == IDX_ACTIVATE) ? 8'(activate_reg)
                      : res_hit ? res_mem[res_ofs] : 8'h00;
  wire drive_en = rd_hit && (iso_read ? cur_bit : state_reg == config_state);

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      isa_data_out <= '0;
      isa_data_oe_out <= 1'b0;
    end
    else if (ior_rise)
    begin
      isa_data_out <= rd_value;
      isa_data_oe_out <= drive_en;
    end
    else if (ior_fall)
      isa_data_oe_out <= 1'b0;
  end

  // ----------------------------------------
  // Activation
  // ----------------------------------------
  // shift chain runs before enabling
  wire act_start = wr_act && data_s[ACTIVATE_BIT] && !activate_reg;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      shift_cnt_reg <= '0;
      cfg_shift_out <= 1'b0;
      card_active_out <= 1'b0;
    end
    else
    begin
      shift_cnt_reg <= act_start ? CFG_SHIFT_BITS : (shift_cnt_reg != '0 ? shift_cnt_reg - 1'b1 : shift_cnt_reg);
      cfg_shift_out <= act_start || shift_cnt_reg > 5'h01;
      // legacy logic held off until active while auto-configuration is on, on at once when it is off
      card_active_out <= !pnp_on || (activate_reg && shift_cnt_reg == '0 && !act_start);
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  a_unlock_rewind: assert property (eec_wr_in && unlock_reg == unlock_first && !eec_is_second |=> unlock_reg == unlock_idle)
    else $error("unlock not rewound by an off-sequence write");
  a_store_start: assert property (store_go |=> store_start_out && eec_rdata_out[EEC_STORE_BIT])
    else $error("armed store write did not start a store");
  a_store_hold: assert property (eec_reg[EEC_STORE_BIT] && !store_done_in && wait_reg != '0 |=> eec_reg[EEC_STORE_BIT])
    else $error("store bit dropped before completion");
  a_unlock_idle_read: assert property (!eec_wr_in |=> $stable(unlock_reg))
    else $error("unlock progress changed without a control write");
  a_gate_off: assert property (!pnp_on |=> state_reg == await_key_state)
    else $error("auto-configuration running while disabled");
  a_key_sleep: assert property (state_reg == await_key_state && pnp_on && key_found |=> state_reg == sleep_state)
    else $error("key did not move to sleep");
  a_await_quiet: assert property (state_reg == await_key_state && $past(state_reg) == await_key_state |-> !$rose(isa_data_oe_out))
    else $error("data driven while waiting for the key");
  a_wake_zero: assert property (pnp_on && awake && !cmd_to_key && wr_wake && wake_match && csn_reg == '0
                                |=> state_reg == isolate_state && bit_ptr_reg == '0)
    else $error("wake zero did not isolate from the first bit");
  a_wake_miss: assert property (pnp_on && awake && !cmd_to_key && wr_wake && !wake_match |=> state_reg == sleep_state)
    else $error("non-matching wake did not sleep");
  a_iso_pattern: assert property ($rose(isa_data_oe_out) && $past(iso_read) |-> isa_data_out == (iso_phase_reg ? ISO_SECOND : ISO_FIRST))
    else $error("wrong isolation pattern driven");
  a_shift_then_on: assert property (act_start |=> cfg_shift_out[*8] ##0 !card_active_out)
    else $error("card enabled before the shift finished");

  c_key_found: cover property (key_found && state_reg == await_key_state);
  c_isolate_lost: cover property (iso_lost);
  c_store_go: cover property (store_go);
  c_activated: cover property ($rose(card_active_out) && pnp_on);

endmodule

// ==== rtl/iaeu_pkg.sv ====
package iaeu_pkg;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int MS_PER_S = 1000;
  localparam int STORE_WAIT_MS = 200;
  localparam int STORE_WAIT_CYCLES = STORE_WAIT_MS * (CLK_HZ / MS_PER_S);
  localparam int STORE_CNT_W = 22;

  // ----------------------------------------
  // EEROM control register layout
  // ----------------------------------------
  localparam int EEC_STORE_BIT = 7;
  localparam int EEC_RECALL_BIT = 6;
  localparam int EEC_BANK_HI_BIT = 5;
  localparam int EEC_UNLOCK_BIT = 4;
  localparam int EEC_BANK_LO_MSB = 3;
  localparam int EEC_BANK_W = 5;
  localparam logic [7:0] EEC_RESET = 8'h06;
  localparam logic [7:0] EEC_SEQ_MASK = 8'hDF;
  localparam logic [7:0] EEC_FIRST = 8'h0C;
  localparam logic [7:0] EEC_SECOND = 8'h1A;

  // ----------------------------------------
  // Auto-configuration ports and indexes
  // ----------------------------------------
  localparam logic [15:0] ISA_INDEX_PORT = 16'h0279;
  localparam logic [15:0] ISA_WDATA_PORT = 16'h0A79;
  localparam logic [5:0] RD_PORT_PAD = 6'h00;
  localparam logic [1:0] RD_PORT_LOW = 2'h3;
  localparam logic [7:0] RD_PORT_RESET = 8'h80;
  localparam logic [7:0] IDX_SET_RD = 8'h00;
  localparam logic [7:0] IDX_ISOLATE = 8'h01;
  localparam logic [7:0] IDX_CFG_CTRL = 8'h02;
  localparam logic [7:0] IDX_WAKE = 8'h03;
  localparam logic [7:0] IDX_CSN = 8'h06;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_RES_BASE = 8'h40;
  localparam int RES_OFS_W = 6;
  localparam int RES_DEPTH = 64;
  localparam int CTRL_RESET_BIT = 0;
  localparam int CTRL_WAIT_KEY_BIT = 1;
  localparam int CTRL_CSN_CLR_BIT = 2;
  localparam int ACTIVATE_BIT = 0;
  localparam logic [7:0] ISO_FIRST = 8'h55;
  localparam logic [7:0] ISO_SECOND = 8'hAA;
  localparam int ID_BITS = 72;
  localparam int ID_PTR_W = 7;
  localparam int KEY_LEN = 32;
  localparam logic [7:0] KEY_FIRST = 8'h6A;
  localparam logic [7:0] KEY_LAST = 8'h39;
  localparam logic [4:0] CFG_SHIFT_BITS = 5'h16;

  // ----------------------------------------
  // Types and helpers
  // ----------------------------------------
  typedef enum logic [1:0] {await_key_state, sleep_state, isolate_state, config_state} iaeu_pnp_state_t;
  typedef enum logic [1:0] {unlock_idle, unlock_first, unlock_armed} iaeu_unlock_t;

  // Next byte of the initiation key sequence
  function automatic logic [7:0] iaeu_key_next(input logic [7:0] v);
    iaeu_key_next = {v[0] ^ v[1], v[7:1]};
  endfunction

  // Five-bit bank field out of a control register value
  function automatic logic [4:0] iaeu_bank_of(input logic [7:0] v);
    iaeu_bank_of = {v[EEC_BANK_HI_BIT], v[EEC_BANK_LO_MSB:0]};
  endfunction

endpackage

// ==== rtl/iaeu_key_match.sv ====
`timescale 1ns/1ns
module iaeu_key_match
  import iaeu_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // Index port writes
  input wire logic enable_in,
  input wire logic wr_in,
  input wire logic [7:0] data_in,
  // Result
  output logic found_out
);
  import iaeu_pkg::*;

  logic [4:0] pos_reg;
  logic [4:0] pos_next;
  logic [7:0] expect_reg;
  logic [7:0] expect_next;
  logic found_next;

  wire match = wr_in && (data_in == expect_reg);
  wire last = (pos_reg == 5'(KEY_LEN - 1));

  assign pos_next = !enable_in ? '0 : !wr_in ? pos_reg : (match && !last) ? pos_reg + 5'h01 : '0;
  assign expect_next = (!enable_in || !match || last) ? (wr_in || !enable_in ? KEY_FIRST : expect_reg)
                     : iaeu_key_next(expect_reg);
  assign found_next = enable_in && match && last;

  always_ff @(posedge clk_in)
  begin
    if (reset_in)
    begin
      pos_reg <= '0;
      expect_reg <= KEY_FIRST;
      found_out <= 1'b0;
    end
    else
    begin
      pos_reg <= pos_next;
      expect_reg <= expect_next;
      found_out <= found_next;
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  a_key_restart: assert property (enable_in && wr_in && !match |=> pos_reg == 5'h00 && expect_reg == KEY_FIRST)
    else $error("key matcher did not restart on a wrong byte");
  a_key_last: assert property (found_out |-> $past(data_in) == KEY_LAST && $past(pos_reg) == 5'(KEY_LEN - 1))
    else $error("key found without the final key byte");

endmodule

// ==== tb/iaeu_isa_host.sv ====
`timescale 1ns/1ns
module iaeu_isa_host
(
  // Clock
  input wire logic clk_in,
  // Card answer
  input wire logic [7:0] card_data_in,
  input wire logic card_oe_in,
  // Bus pins
  output logic [15:0] bus_addr_out,
  output logic [7:0] bus_data_out,
  output logic iow_out,
  output logic ior_out
);
  logic [7:0] host_data = 8'h00;
  logic [7:0] other_data = 8'h00;
  logic [7:0] idle_cnt = 8'h00;
  logic host_drive = 1'b0;
  logic other_drive = 1'b0;
  // ----
  // Bus level
  // ----
  // Undriven bus floats
  // Idle level keeps moving, so it never forms 0x55 then 0xAA
  assign bus_data_out = card_oe_in ? card_data_in : host_drive ? host_data : other_drive ? other_data : ~idle_cnt;
  always @(posedge clk_in) idle_cnt <= idle_cnt + 8'h01;
  initial
  begin
    bus_addr_out = 16'h0000;
    iow_out = 1'b0;
    ior_out = 1'b0;
  end
  // ----
  // Bus cycles
  // ----
  // Strobe held well past the sync delay
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_in);
    bus_addr_out <= a;
    host_data <= d;
    host_drive <= 1'b1;
    iow_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    iow_out <= 1'b0;
    repeat (6) @(posedge clk_in);
    host_drive <= 1'b0;
  endtask
  // One read of a bit pair
  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic oe);
    @(posedge clk_in);
    bus_addr_out <= a;
    ior_out <= 1'b1;
    repeat (5) @(posedge clk_in);
    #10;
    d = bus_data_out;
    oe = card_oe_in;
    @(posedge clk_in);
    ior_out <= 1'b0;
    repeat (6) @(posedge clk_in);
  endtask
  // Another card answering the isolation reads
  task automatic other(input logic on, input logic [7:0] v);
    other_drive <= on;
    other_data <= v;
  endtask
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench;
  import iaeu_pkg::*;
  typedef struct packed {logic [7:0] v; logic st;} iaeu_row_t;
  // Arming rows, banks 5 and 17 only
  iaeu_row_t rows [13] = '{'{8'h0C, 1'b0}, '{8'h1A, 1'b0}, '{8'h85, 1'b1}, '{8'h2C, 1'b0}, '{8'h3A, 1'b0},
    '{8'hA1, 1'b1}, '{8'h0C, 1'b0}, '{8'h1A, 1'b0}, '{8'h0C, 1'b0}, '{8'h0C, 1'b0}, '{8'h85, 1'b0},
    '{8'h1A, 1'b0}, '{8'h85, 1'b0}};
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic eec_wr = 1'b0;
  logic [7:0] eec_wdata = 8'h00;
  logic store_done = 1'b0;
  logic acfg_en = 1'b1;
  logic strap = 1'b1;
  logic recall_start;
  logic [15:0] rdp = 16'h0203;
  logic [15:0] isa_addr;
  logic [7:0] isa_din, isa_dout, eec_rdata, rdv;
  logic [7:0] key [KEY_LEN];
  logic isa_iow, isa_ior, isa_oe, store_start, cfg_shift, card_active, oe;
  logic [4:0] store_bank;
  int num_errors = 0;
  int checks = 0;
  int shift_cnt = 0;
  initial
  begin
    forever #50 clk_in = ~clk_in;
  end
  always @(posedge clk_in) if (cfg_shift === 1'b1) shift_cnt <= shift_cnt + 1;
  // Short store timeout keeps the run brief
  iaeu_top #(.SERIAL_ID(72'h0D), .STORE_WAIT(50)) i_iaeu_top (.clk_in(clk_in), .reset_in(reset_in),
    .isa_addr_in(isa_addr), .isa_data_in(isa_din), .isa_iow_in(isa_iow), .isa_ior_in(isa_ior),
    .isa_data_out(isa_dout), .isa_data_oe_out(isa_oe), .eec_wr_in(eec_wr), .eec_wdata_in(eec_wdata),
    .eec_rdata_out(eec_rdata), .store_done_in(store_done), .store_start_out(store_start),
    .recall_start_out(recall_start), .store_bank_out(store_bank), .autoconfig_enable_in(acfg_en),
    .strap_address_pin_six_in(strap), .cfg_shift_out(cfg_shift), .card_active_out(card_active));
  iaeu_isa_host i_iaeu_isa_host (.clk_in(clk_in), .card_data_in(isa_dout), .card_oe_in(isa_oe),
    .bus_addr_out(isa_addr), .bus_data_out(isa_din), .iow_out(isa_iow), .ior_out(isa_ior));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ewr(input logic [7:0] v);
    @(posedge clk_in);
    eec_wr <= 1'b1;
    eec_wdata <= v;
    @(posedge clk_in);
    eec_wr <= 1'b0;
    #10;
  endtask
  task automatic wa(input logic [7:0] d);
    i_iaeu_isa_host.wr(ISA_INDEX_PORT, d);
  endtask
  task automatic wd(input logic [7:0] d);
    i_iaeu_isa_host.wr(ISA_WDATA_PORT, d);
  endtask
  task automatic wake(input logic [7:0] n);
    wa(IDX_WAKE);
    wd(n);
  endtask
  task automatic rx(input logic eo, input logic [7:0] ed);
    i_iaeu_isa_host.rd(rdp, rdv, oe);
    chk(oe, eo);
    if (eo) chk(rdv, ed);
  endtask
  task automatic print_verdict;
    if (num_errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    #1_000_000;
    num_errors++;
    print_verdict();
  end
  initial
  begin
    key[0] = KEY_FIRST;
    for (int i = 1; i < KEY_LEN; i++) key[i] = {key[i-1][0] ^ key[i-1][1], key[i-1][7:1]};
    repeat (2) @(posedge clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    #10;
    chk(eec_rdata, 8'h06);
    chk(card_active, 1'b0);
    foreach (rows[i])
    begin
      ewr(rows[i].v);
      chk(store_start, rows[i].st);
      chk(eec_rdata, {rows[i].st, rows[i].v[6:0]});
      if (rows[i].st) chk(store_bank, {rows[i].v[5], rows[i].v[3:0]});
      @(posedge clk_in);
      store_done <= rows[i].st;
      @(posedge clk_in);
      store_done <= 1'b0;
      #10;
      chk(eec_rdata[7], 1'b0);
    end
    ewr(8'h46);
    chk(recall_start, 1'b1);
    chk(eec_rdata, 8'h46);
    // Bus traffic between arming writes, then no done
    ewr(8'h0C);
    ewr(8'h1A);
    wa(8'h00);
    ewr(8'h85);
    chk(store_start, 1'b1);
    repeat (20) @(posedge clk_in);
    #10;
    chk(eec_rdata[7], 1'b1);
    repeat (50) @(posedge clk_in);
    #10;
    chk(eec_rdata[7], 1'b0);
    rx(1'b0, 8'h00);
    for (int i = 0; i < KEY_LEN; i++)
    begin
      if (i == 16) wa(8'h00);
      wa(key[i]);
    end
    wake(8'h00);
    wa(IDX_ISOLATE);
    rx(1'b0, 8'h00);
    for (int i = 0; i < KEY_LEN; i++) wa(key[i]);
    wake(8'h00);
    wa(IDX_ISOLATE);
    rx(1'b1, 8'h55);
    rx(1'b1, 8'hAA);
    i_iaeu_isa_host.other(1'b1, 8'h55);
    rx(1'b0, 8'h00);
    i_iaeu_isa_host.other(1'b1, 8'hAA);
    rx(1'b0, 8'h00);
    i_iaeu_isa_host.other(1'b0, 8'h00);
    rx(1'b0, 8'h00);
    wake(8'h00);
    wa(IDX_SET_RD);
    wd(8'h90);
    wa(IDX_ISOLATE);
    rx(1'b0, 8'h00);
    rdp = 16'h0243;
    rx(1'b1, 8'h55);
    rx(1'b1, 8'hAA);
    wa(IDX_CSN);
    wd(8'h01);
    rx(1'b1, 8'h01);
    wa(8'h07);
    rx(1'b1, 8'h00);
    wa(8'h40);
    wd(8'hA5);
    rx(1'b1, 8'hA5);
    wake(8'h02);
    rx(1'b0, 8'h00);
    wake(8'h01);
    wa(IDX_CSN);
    rx(1'b1, 8'h01);
    chk(card_active, 1'b0);
    wa(IDX_ACTIVATE);
    wd(8'h01);
    repeat (40) @(posedge clk_in);
    #10;
    chk(shift_cnt[7:0], 8'h16);
    chk(card_active, 1'b1);
    wa(IDX_CFG_CTRL);
    wd(8'h04);
    wa(IDX_CSN);
    rx(1'b1, 8'h00);
    wa(IDX_CFG_CTRL);
    wd(8'h01);
    chk(card_active, 1'b0);
    wake(8'h01);
    wa(IDX_CSN);
    rx(1'b0, 8'h00);
    for (int i = 0; i < KEY_LEN; i++) wa(key[i]);
    wake(8'h00);
    wa(IDX_CFG_CTRL);
    wd(8'h02);
    wa(IDX_ISOLATE);
    rx(1'b0, 8'h00);
    acfg_en <= 1'b0;
    repeat (5) @(posedge clk_in);
    #10;
    chk(card_active, 1'b1);
    @(posedge clk_in);
    strap <= 1'b0;
    repeat (5) @(posedge clk_in);
    acfg_en <= 1'b1;
    repeat (5) @(posedge clk_in);
    #10;
    chk(card_active, 1'b1);
    print_verdict();
  end
endmodule
